// [hw/pos_output_stage.sv]
// PWM output stage: dead-time, masking, fault brake, polarity and pin routing
//
// Operation
// - Route bit 3 gives the channel-3 pin to PWM, else general I/O.
// - Route bit 2 gives the channel-2 pin to PWM, else general I/O.
// - Pair dead-time enables act only in complementary mode.
// - Enabled dead-time delays rising edges of both pair signals.
// - Nine-bit count, msb in enable bit 4; lasts count plus one clocks.
// - Count is used only in complementary mode with the pair enabled.
// - Mask enable replaces a channel with its mask value bit.
// - A masked channel is driven to its mask value unless braked, inverted where its polarity bit is set.
// - Brake flag sets on a selected brake pin edge while input enabled.
// - Brake values hold after flag clear until run is set again.
// - Edge select bit 6: zero falling, one rising.
// - During brake, channels take their brake value bits 5 to 0.
// - Polarity bit one inverts the channel onto its pin.
// - Dead-time registers accept writes only after the unlock sequence.
// - Brake forces channels 0 to 5 and clears the run bit.
//
// Register map
// Pin routing at 0xc6: bit 3 channel 3 pin, bit 2 channel 2 pin
// Output inversion at 0xd6, bits 5 to 0
// Brake control at 0xd7: flag bit 7, edge select bit 6, brake values bits 5 to 0
// Dead-time enables at 0xf9: pairs in bits 2 to 0, count msb in bit 4; protected
// Dead-time count low byte at 0xfa; protected
// Mask enables at 0xfb, bits 5 to 0
// Mask values at 0xfc, bits 5 to 0
// Unlock at 0x80: keys on write, window open in bit 0 on read
// Event status at 0x81: bit 0 brake, bit 1 refused write; write one to clear
// Event mask at 0x82, same layout as the status
//
// Notes
// Two clocks from generator input to pins when no dead-time is inserted.
// A new dead-time count takes effect at the next edge of each pair.
// The brake flag can only be written to zero; a brake edge in the same cycle wins.
`timescale 1ns/1ps
module pos_output_stage
	import pos_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  reset_n_i,
	// Register port
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic      [7:0]            reg_rdata_o,
	// Generator side
	input  wire logic [POS_NUM_CH-1:0] gen_signal_i,
	input  wire logic                  complementary_i,
	input  wire logic                  generator_run_i,
	input  wire logic                  brake_input_enable_i,
	output logic                       generator_run_clear_o,
	// Brake pin
	input  wire logic                  brake_pin_i,
	// Channel outputs
	output logic      [POS_NUM_CH-1:0] pwm_out_o,
	// Shared pins, general I/O side
	input  wire logic                  gpio_ch2_out_i,
	input  wire logic                  gpio_ch2_oe_i,
	input  wire logic                  gpio_ch3_out_i,
	input  wire logic                  gpio_ch3_oe_i,
	// Shared pins
	output logic                       pin_ch2_out_o,
	output logic                       pin_ch2_oe_o,
	output logic                       pin_ch3_out_o,
	output logic                       pin_ch3_oe_o,
	// Interrupt
	output logic                       irq_o
);

	typedef struct packed {
		// Software registers
		logic                    pin_route_ch3;
		logic                    pin_route_ch2;
		logic [POS_NUM_PAIRS-1:0] deadtime_en;
		logic                    deadtime_count_msb;
		logic [7:0]              deadtime_count_low;
		logic [POS_NUM_CH-1:0]   mask_enable;
		logic [POS_NUM_CH-1:0]   mask_value;
		logic                    brake_flag;
		logic                    brake_edge_select;
		logic [POS_NUM_CH-1:0]   brake_value;
		logic [POS_NUM_CH-1:0]   invert_output;
		// Event status and unlock sequencer
		logic [1:0]              irq_status;
		logic [1:0]              irq_mask;
		pos_unlock_state_t       unlock_state;
		logic [1:0]              unlock_timer;
		// Edge detectors and brake hold
		logic                    brake_pin_prev;
		logic                    run_prev;
		logic                    brake_hold;
		logic                    run_clear;
		// Registered outputs
		logic [7:0]              rdata;
		logic [POS_NUM_CH-1:0]   pwm_out;
		logic                    pin_ch2_out;
		logic                    pin_ch2_oe;
		logic                    pin_ch3_out;
		logic                    pin_ch3_oe;
	} pos_state_t;

	pos_state_t            s_q;
	pos_state_t            s_d;
	logic [POS_NUM_CH-1:0] dt_signal;
	logic [POS_DT_W-1:0]   deadtime_count;
	logic [POS_NUM_CH-1:0] masked;
	logic [POS_NUM_CH-1:0] braked;
	logic [POS_NUM_CH-1:0] polar;
	logic                  brake_edge;
	logic                  brake_trigger;
	logic                  run_set;
	logic                  prot_addr;
	logic                  prot_write;
	logic                  prot_refused;
	logic [1:0]            irq_event;
	logic [1:0]            irq_clear;

	// Full nine-bit dead-time count
	assign deadtime_count = {s_q.deadtime_count_msb, s_q.deadtime_count_low};

	// One dead-time inserter per complementary pair
	genvar p;
	generate
		for (p = 0; p < POS_NUM_PAIRS; p = p + 1) begin : g_pair
			pos_deadtime u_deadtime (
				.clk_sys_i (clk_sys_i),
				.reset_n_i (reset_n_i),
				.apply_i   (complementary_i & s_q.deadtime_en[p]),
				.count_i   (deadtime_count),
				.sig_i     (gen_signal_i[2*p+1:2*p]),
				.sig_o     (dt_signal[2*p+1:2*p])
			);
		end
	endgenerate

	// Channel chain after dead-time: mask, brake override, polarity
	// The brake sits after the mask so that a masked channel still brakes safely
	genvar c;
	generate
		for (c = 0; c < POS_NUM_CH; c = c + 1) begin : g_chan
			// Mask value replaces the channel while its mask enable is set
			assign masked[c] = s_q.mask_enable[c] ? s_q.mask_value[c]
				: dt_signal[c];
			// Brake value overrides while the hold stands
			assign braked[c] = s_q.brake_hold ? s_q.brake_value[c] : masked[c];
			// Inversion is the last stage before the pins
			assign polar[c]  = braked[c] ^ s_q.invert_output[c];
		end
	endgenerate

	// Brake pin edge detection and run-bit restart detection
	always_comb begin
		if (s_q.brake_edge_select) begin
			brake_edge = brake_pin_i & ~s_q.brake_pin_prev;
		end else begin
			brake_edge = ~brake_pin_i & s_q.brake_pin_prev;
		end
		brake_trigger = brake_input_enable_i & brake_edge;
		// A rise of the run bit is the only release of the brake hold
		run_set       = generator_run_i & ~s_q.run_prev;
	end

	// Protected write qualification
	always_comb begin
		prot_addr = (reg_addr_i == POS_ADDR_DEADTIME_ENABLE)
			| (reg_addr_i == POS_ADDR_DEADTIME_COUNT_LOW);
		prot_write   = reg_wr_i & prot_addr & (s_q.unlock_state == POS_UNL_OPEN);
		prot_refused = reg_wr_i & prot_addr & (s_q.unlock_state != POS_UNL_OPEN);
	end

	// Event sources, and the write-one-to-clear mask of the status
	always_comb begin
		irq_event                      = 2'h0;
		irq_event[POS_BIT_IRQ_BRAKE]   = brake_trigger;
		irq_event[POS_BIT_IRQ_REFUSED] = prot_refused;
		irq_clear = 2'h0;
		if (reg_wr_i && (reg_addr_i == POS_ADDR_IRQ_STATUS)) begin
			irq_clear = reg_wdata_i[1:0];
		end
	end

	// Next state: registers, unlock sequencer, brake, outputs
	always_comb begin
		s_d                = s_q;
		s_d.brake_pin_prev = brake_pin_i;
		s_d.run_prev       = generator_run_i;
		s_d.run_clear      = brake_trigger;

		// Register writes
		if (reg_wr_i) begin
			if (reg_addr_i == POS_ADDR_PWM_PIN_ROUTE_B) begin
				s_d.pin_route_ch3 = reg_wdata_i[POS_BIT_PIN_ROUTE_CH3];
				s_d.pin_route_ch2 = reg_wdata_i[POS_BIT_PIN_ROUTE_CH2];
			end else if (reg_addr_i == POS_ADDR_OUTPUT_POLARITY) begin
				s_d.invert_output = reg_wdata_i[POS_NUM_CH-1:0];
			end else if (reg_addr_i == POS_ADDR_BRAKE_CONTROL_DATA) begin
				s_d.brake_edge_select = reg_wdata_i[POS_BIT_BRAKE_EDGE_SELECT];
				s_d.brake_value       = reg_wdata_i[POS_NUM_CH-1:0];
				if (!reg_wdata_i[POS_BIT_BRAKE_FLAG]) begin
					s_d.brake_flag = 1'b0; // Software clear only
				end
			end else if (reg_addr_i == POS_ADDR_DEADTIME_ENABLE) begin
				// Protected: taken only while the unlock window is open
				if (prot_write) begin
					s_d.deadtime_en        = reg_wdata_i[POS_NUM_PAIRS-1:0];
					s_d.deadtime_count_msb = reg_wdata_i[POS_BIT_DEADTIME_COUNT_MSB];
				end
			end else if (reg_addr_i == POS_ADDR_DEADTIME_COUNT_LOW) begin
				if (prot_write) begin
					s_d.deadtime_count_low = reg_wdata_i;
				end
			end else if (reg_addr_i == POS_ADDR_OUTPUT_MASK_ENABLE) begin
				s_d.mask_enable = reg_wdata_i[POS_NUM_CH-1:0];
			end else if (reg_addr_i == POS_ADDR_OUTPUT_MASK_VALUE) begin
				s_d.mask_value = reg_wdata_i[POS_NUM_CH-1:0];
			end else if (reg_addr_i == POS_ADDR_IRQ_MASK) begin
				s_d.irq_mask = reg_wdata_i[1:0];
			end
		end

		// Hardware set of the brake flag wins over a software clear
		if (brake_trigger) begin
			s_d.brake_flag = 1'b1;
		end

		// Brake hold releases only when the run bit is set again
		if (brake_trigger) begin
			s_d.brake_hold = 1'b1;
		end else if (run_set) begin
			s_d.brake_hold = 1'b0;
		end

		// Sticky status, write one to clear, events win
		s_d.irq_status = (s_q.irq_status & ~irq_clear) | irq_event;

		// Unlock sequencer: key, key, then a short window for one protected write
		case (s_q.unlock_state)
			POS_UNL_IDLE: begin
				// First key starts the sequence
				if (reg_wr_i && (reg_addr_i == POS_ADDR_WRITE_UNLOCK)
					&& (reg_wdata_i == POS_UNLOCK_KEY_1)) begin
					s_d.unlock_state = POS_UNL_KEY;
				end
			end
			POS_UNL_KEY: begin
				// The very next write must be the second key
				if (reg_wr_i) begin
					if ((reg_addr_i == POS_ADDR_WRITE_UNLOCK)
						&& (reg_wdata_i == POS_UNLOCK_KEY_2)) begin
						s_d.unlock_state = POS_UNL_OPEN;
						s_d.unlock_timer = POS_UNLOCK_WINDOW;
					end else begin
						s_d.unlock_state = POS_UNL_IDLE;
					end
				end
			end
			POS_UNL_OPEN: begin
				// Window counts down; one protected write closes it
				if (prot_write || (s_q.unlock_timer == 2'h0)) begin
					s_d.unlock_state = POS_UNL_IDLE;
				end else begin
					s_d.unlock_timer = s_q.unlock_timer - 2'h1;
				end
			end
			default: begin
				s_d.unlock_state = POS_UNL_IDLE;
			end
		endcase

		// Read data, valid in the cycle after the strobe
		s_d.rdata = 8'h00;
		// Unused and unmapped bits stay zero
		if (reg_rd_i) begin
			if (reg_addr_i == POS_ADDR_PWM_PIN_ROUTE_B) begin
				s_d.rdata[POS_BIT_PIN_ROUTE_CH3] = s_q.pin_route_ch3;
				s_d.rdata[POS_BIT_PIN_ROUTE_CH2] = s_q.pin_route_ch2;
			end else if (reg_addr_i == POS_ADDR_OUTPUT_POLARITY) begin
				s_d.rdata[POS_NUM_CH-1:0] = s_q.invert_output;
			end else if (reg_addr_i == POS_ADDR_BRAKE_CONTROL_DATA) begin
				s_d.rdata[POS_BIT_BRAKE_FLAG]        = s_q.brake_flag;
				s_d.rdata[POS_BIT_BRAKE_EDGE_SELECT] = s_q.brake_edge_select;
				s_d.rdata[POS_NUM_CH-1:0]            = s_q.brake_value;
			end else if (reg_addr_i == POS_ADDR_DEADTIME_ENABLE) begin
				s_d.rdata[POS_NUM_PAIRS-1:0]          = s_q.deadtime_en;
				s_d.rdata[POS_BIT_DEADTIME_COUNT_MSB] = s_q.deadtime_count_msb;
			end else if (reg_addr_i == POS_ADDR_DEADTIME_COUNT_LOW) begin
				s_d.rdata = s_q.deadtime_count_low;
			end else if (reg_addr_i == POS_ADDR_OUTPUT_MASK_ENABLE) begin
				s_d.rdata[POS_NUM_CH-1:0] = s_q.mask_enable;
			end else if (reg_addr_i == POS_ADDR_OUTPUT_MASK_VALUE) begin
				s_d.rdata[POS_NUM_CH-1:0] = s_q.mask_value;
			end else if (reg_addr_i == POS_ADDR_WRITE_UNLOCK) begin
				s_d.rdata[POS_BIT_UNLOCK_OPEN] = (s_q.unlock_state == POS_UNL_OPEN);
			end else if (reg_addr_i == POS_ADDR_IRQ_STATUS) begin
				s_d.rdata[1:0] = s_q.irq_status;
			end else if (reg_addr_i == POS_ADDR_IRQ_MASK) begin
				s_d.rdata[1:0] = s_q.irq_mask;
			end
		end

		// Channel outputs and shared pin routing
		s_d.pwm_out = polar;
		// A routed pin is driven by its channel with the enable held high
		if (s_q.pin_route_ch3) begin
			s_d.pin_ch3_out = polar[3];
			s_d.pin_ch3_oe  = 1'b1;
		end else begin
			s_d.pin_ch3_out = gpio_ch3_out_i;
			s_d.pin_ch3_oe  = gpio_ch3_oe_i;
		end
		if (s_q.pin_route_ch2) begin
			s_d.pin_ch2_out = polar[2];
			s_d.pin_ch2_oe  = 1'b1;
		end else begin
			s_d.pin_ch2_out = gpio_ch2_out_i;
			s_d.pin_ch2_oe  = gpio_ch2_oe_i;
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q              <= '0;
			s_q.unlock_state <= POS_UNL_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign reg_rdata_o           = s_q.rdata;
	assign generator_run_clear_o = s_q.run_clear;
	assign pwm_out_o             = s_q.pwm_out;
	assign pin_ch2_out_o         = s_q.pin_ch2_out;
	assign pin_ch2_oe_o          = s_q.pin_ch2_oe;
	assign pin_ch3_out_o         = s_q.pin_ch3_out;
	assign pin_ch3_oe_o          = s_q.pin_ch3_oe;
	assign irq_o                 = |(s_q.irq_status & s_q.irq_mask); // Level, status bits enabled in the mask

endmodule // pos_output_stage

// [hw/pos_pkg.sv]
// Constants, register map and types of the PWM output stage
package pos_pkg;

	// Widths and counts
	localparam int POS_NUM_CH    = 6;
	localparam int POS_NUM_PAIRS = 3;
	localparam int POS_DT_W      = 9;

	// System clock rate; one dead-time step is one period of it
	localparam int POS_SYSTEM_CLOCK_FREQ = 40000000;
	localparam int POS_CLK_PERIOD_NS     = 1000000000 / POS_SYSTEM_CLOCK_FREQ;

	// Register offsets
	localparam logic [7:0] POS_ADDR_PWM_PIN_ROUTE_B    = 8'hc6;
	localparam logic [7:0] POS_ADDR_OUTPUT_POLARITY    = 8'hd6;
	localparam logic [7:0] POS_ADDR_BRAKE_CONTROL_DATA = 8'hd7;
	localparam logic [7:0] POS_ADDR_DEADTIME_ENABLE    = 8'hf9;
	localparam logic [7:0] POS_ADDR_DEADTIME_COUNT_LOW = 8'hfa;
	localparam logic [7:0] POS_ADDR_OUTPUT_MASK_ENABLE = 8'hfb;
	localparam logic [7:0] POS_ADDR_OUTPUT_MASK_VALUE  = 8'hfc;
	localparam logic [7:0] POS_ADDR_WRITE_UNLOCK       = 8'h80;
	localparam logic [7:0] POS_ADDR_IRQ_STATUS         = 8'h81;
	localparam logic [7:0] POS_ADDR_IRQ_MASK           = 8'h82;

	// Field positions
	localparam int POS_BIT_PIN_ROUTE_CH3      = 3;
	localparam int POS_BIT_PIN_ROUTE_CH2      = 2;
	localparam int POS_BIT_DEADTIME_COUNT_MSB = 4;
	localparam int POS_BIT_BRAKE_FLAG         = 7;
	localparam int POS_BIT_BRAKE_EDGE_SELECT  = 6;
	localparam int POS_BIT_IRQ_BRAKE          = 0;
	localparam int POS_BIT_IRQ_REFUSED        = 1;
	localparam int POS_BIT_UNLOCK_OPEN        = 0;

	// Reset values
	localparam logic [7:0] POS_RST_REG  = 8'h00;
	localparam logic [1:0] POS_RST_IRQ  = 2'h0;
	localparam logic [8:0] POS_RST_DT   = 9'h000;

	// Unlock sequence: two key writes open a short window for one write
	localparam logic [7:0] POS_UNLOCK_KEY_1  = 8'haa;
	localparam logic [7:0] POS_UNLOCK_KEY_2  = 8'h55;
	localparam logic [1:0] POS_UNLOCK_WINDOW = 2'h3;

	// Unlock sequencer states
	typedef enum logic [2:0] {
		POS_UNL_IDLE = 3'b001,
		POS_UNL_KEY  = 3'b010,
		POS_UNL_OPEN = 3'b100
	} pos_unlock_state_t;

endpackage

// [hw/pos_deadtime.sv]
// Dead-time insertion for one complementary channel pair
`timescale 1ns/1ps
module pos_deadtime
	import pos_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys_i,
	input  wire logic                reset_n_i,
	// Control
	input  wire logic                apply_i,
	input  wire logic [POS_DT_W-1:0] count_i,
	// Pair signals
	input  wire logic [1:0]          sig_i,
	output logic      [1:0]          sig_o
);

	typedef struct packed {
		logic [1:0]          prev;
		logic                busy;
		logic [POS_DT_W-1:0] timer;
		logic [1:0]          out;
	} pos_dt_state_t;

	pos_dt_state_t s_q;
	pos_dt_state_t s_d;

	// Any edge on either signal restarts the count; high outputs wait for it to expire
	always_comb begin
		s_d      = s_q;
		s_d.prev = sig_i;
		if (sig_i != s_q.prev) begin
			s_d.busy  = 1'b1;
			s_d.timer = count_i;
		end else if (s_q.busy) begin
			if (s_q.timer == POS_RST_DT) begin
				s_d.busy = 1'b0;
			end else begin
				s_d.timer = s_q.timer - 9'h001; // Count plus one periods in all
			end
		end
		if (apply_i) begin
			s_d.out = sig_i & {2{~s_d.busy}};
		end else begin
			s_d.out = sig_i; // No delay
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sig_o = s_q.out;

endmodule // pos_deadtime

// [testbench/pos_output_stage_monitor.sv]
// Port assertions for the PWM output stage
`timescale 1ns/1ps
module pos_stage_monitor
	import pos_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       reset_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Brake
	input wire logic       brake_input_enable_i,
	input wire logic       brake_pin_i,
	input wire logic       generator_run_clear_o,
	// Shared pins
	input wire logic       gpio_ch2_out_i,
	input wire logic       gpio_ch2_oe_i,
	input wire logic       gpio_ch3_out_i,
	input wire logic       gpio_ch3_oe_i,
	input wire logic       pin_ch2_out_o,
	input wire logic       pin_ch2_oe_o,
	input wire logic       pin_ch3_out_o,
	input wire logic       pin_ch3_oe_o
);
	logic [1:0] route_q;
	logic       sel_q;
	logic       pin_q;
	logic       up_q;
	logic       trig_q;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	// Mirror route and edge select; work out when the brake must fire
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			route_q <= 2'h0;
			sel_q   <= 1'b0;
			pin_q   <= 1'b0;
			up_q    <= 1'b0;
			trig_q  <= 1'b0;
		end else begin
			if (reg_wr_i && reg_addr_i == POS_ADDR_PWM_PIN_ROUTE_B)
				route_q <= reg_wdata_i[3:2];
			if (reg_wr_i && reg_addr_i == POS_ADDR_BRAKE_CONTROL_DATA)
				sel_q <= reg_wdata_i[6];
			pin_q  <= brake_pin_i;
			up_q   <= 1'b1;
			trig_q <= up_q && brake_input_enable_i
				&& (sel_q ? (brake_pin_i && !pin_q) : (!brake_pin_i && pin_q));
		end
	end

	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside its slot");
	a_rdata_unmapped: assert property (reg_rd_i && !(reg_addr_i inside {8'hc6, 8'hd6,
		8'hd7, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'h80, 8'h81, 8'h82}) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_route_read: assert property (
		reg_rd_i && reg_addr_i == POS_ADDR_PWM_PIN_ROUTE_B |=> reg_rdata_o[3:2] == $past(route_q))
		else $error("route bits read back wrong");
	a_pin3_gpio: assert property ($past(reset_n_i) && !$past(route_q[1]) |->
		pin_ch3_out_o == $past(gpio_ch3_out_i) && pin_ch3_oe_o == $past(gpio_ch3_oe_i))
		else $error("channel 3 pin not on general io");
	a_pin2_gpio: assert property ($past(reset_n_i) && !$past(route_q[0]) |->
		pin_ch2_out_o == $past(gpio_ch2_out_i) && pin_ch2_oe_o == $past(gpio_ch2_oe_i))
		else $error("channel 2 pin not on general io");
	a_pin_routed: assert property ($past(reset_n_i) |->
		(!$past(route_q[1]) || pin_ch3_oe_o) && (!$past(route_q[0]) || pin_ch2_oe_o))
		else $error("routed pin not driven");
	a_brake_fires: assert property (trig_q |-> generator_run_clear_o)
		else $error("brake edge did not clear run");
	a_clear_cause: assert property (generator_run_clear_o |-> trig_q)
		else $error("run cleared without brake edge");
	a_clear_single: assert property ($rose(generator_run_clear_o) |=>
		$fell(generator_run_clear_o)) else $error("run clear pulse too long");
endmodule // pos_stage_monitor

bind pos_output_stage pos_stage_monitor pos_stage_monitor_i (
	.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .brake_input_enable_i(brake_input_enable_i),
	.brake_pin_i(brake_pin_i), .generator_run_clear_o(generator_run_clear_o),
	.gpio_ch2_out_i(gpio_ch2_out_i), .gpio_ch2_oe_i(gpio_ch2_oe_i),
	.gpio_ch3_out_i(gpio_ch3_out_i), .gpio_ch3_oe_i(gpio_ch3_oe_i),
	.pin_ch2_out_o(pin_ch2_out_o), .pin_ch2_oe_o(pin_ch2_oe_o),
	.pin_ch3_out_o(pin_ch3_out_o), .pin_ch3_oe_o(pin_ch3_oe_o));

// [testbench/pos_switch_model.sv]
// Half-bridge power switches driven by the channel outputs
`timescale 1ns/1ps
module pos_switch_model
	import pos_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  reset_n_i,
	// Gate drives
	input  wire logic [POS_NUM_CH-1:0] gate_i,
	// Pairs conducting together
	output logic      [2:0]            short_o
);
	// Both switches of one bridge on together is a short; remembered until reset
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			short_o <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++)
				short_o[p] <= short_o[p] | (gate_i[2*p] & gate_i[2*p+1]);
		end
	end
endmodule // pos_switch_model

// [testbench/pos_output_stage_test.sv]
// Self-checking bench for the PWM output stage
`timescale 1ns/1ps
module pos_output_stage_test;
	import pos_pkg::*;
	logic       clk = 0, reset_n = 0, wr = 0, rd = 0, comp = 0, run = 0;
	logic       brk_en = 0, brk_pin = 0, run_clr, irq;
	logic       g2o = 0, g2e = 0, g3o = 0, g3e = 0, p2o, p2e, p3o, p3e;
	logic [7:0] addr = 0, wdata = 0, rdata, d;
	logic [5:0] gen = 0, pwm;
	logic [2:0] short;
	logic       s;
	int         fails = 0, cmp_count = 0, base, n;
	localparam logic [7:0] REGS [7] = '{8'hc6, 8'hd6, 8'hd7, 8'hf9, 8'hfa, 8'hfb, 8'hfc};

	// System clock, 25 ns
	always #12.5 clk = ~clk;

	pos_output_stage pos_output_stage_i (.clk_sys_i(clk), .reset_n_i(reset_n),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .gen_signal_i(gen), .complementary_i(comp),
		.generator_run_i(run), .brake_input_enable_i(brk_en),
		.generator_run_clear_o(run_clr), .brake_pin_i(brk_pin), .pwm_out_o(pwm),
		.gpio_ch2_out_i(g2o), .gpio_ch2_oe_i(g2e), .gpio_ch3_out_i(g3o),
		.gpio_ch3_oe_i(g3e), .pin_ch2_out_o(p2o), .pin_ch2_oe_o(p2e),
		.pin_ch3_out_o(p3o), .pin_ch3_oe_o(p3e), .irq_o(irq));
	pos_switch_model pos_switch_model_i (.clk_sys_i(clk), .reset_n_i(reset_n), .gate_i(pwm),
		.short_o(short));

	task automatic wait_n(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Read slot lands in the cycle after the strobe
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic unlock_wr(input logic [7:0] a, input logic [7:0] v);
		wr_reg(POS_ADDR_WRITE_UNLOCK, POS_UNLOCK_KEY_1);
		wr_reg(POS_ADDR_WRITE_UNLOCK, POS_UNLOCK_KEY_2);
		wr_reg(a, v);
	endtask
	// Cycles from a channel 0 rise to its output
	task automatic measure(output int m);
		@(posedge clk);
		gen <= 6'h00;
		wait_n(300);
		@(posedge clk);
		gen <= 6'h01;
		m = 0;
		while (pwm[0] !== 1'b1 && m < 600) begin
			wait_n(1);
			m++;
		end
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("watchdog expired");
		end_sim();
	end

	// Test sequence
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		foreach (REGS[i])
			chk_rd(REGS[i], 8'h00);
		wr_reg(8'h90, 8'hff);
		chk_rd(8'h90, 8'h00);
		done("reset");
		@(posedge clk);
		{g3o, g3e, g2o, g2e} <= 4'b0111;
		wait_n(3);
		chk({4'h0, p3o, p3e, p2o, p2e}, 8'h07);
		wr_reg(POS_ADDR_PWM_PIN_ROUTE_B, 8'h0c);
		wr_reg(POS_ADDR_OUTPUT_MASK_ENABLE, 8'h3f);
		wr_reg(POS_ADDR_OUTPUT_MASK_VALUE, 8'h08);
		wait_n(4);
		chk({4'h0, p3o, p3e, p2o, p2e}, 8'h0d);
		chk_rd(POS_ADDR_PWM_PIN_ROUTE_B, 8'h0c);
		done("routing");
		@(posedge clk);
		gen <= 6'h15;
		wr_reg(POS_ADDR_OUTPUT_MASK_ENABLE, 8'h0f);
		wr_reg(POS_ADDR_OUTPUT_MASK_VALUE, 8'h0a);
		wait_n(4);
		chk({2'h0, pwm}, 8'h1a);
		wr_reg(POS_ADDR_OUTPUT_POLARITY, 8'h30);
		wait_n(4);
		chk({2'h0, pwm}, 8'h2a);
		wr_reg(POS_ADDR_OUTPUT_POLARITY, 8'h00);
		wr_reg(POS_ADDR_OUTPUT_MASK_ENABLE, 8'h00);
		wait_n(4);
		chk({2'h0, pwm}, 8'h15);
		done("mask");
		@(posedge clk);
		gen <= 6'h00;
		wr_reg(POS_ADDR_IRQ_MASK, 8'h01);
		for (int k = 0; k < 2; k++) begin
			s = k[0];
			wr_reg(POS_ADDR_BRAKE_CONTROL_DATA, {1'b0, s, 6'h2a});
			@(posedge clk);
			brk_pin <= !s;
			brk_en  <= 1'b1;
			wait_n(2);
			@(posedge clk);
			brk_pin <= s;
			wait_n(1);
			chk({7'h0, run_clr}, 8'h01);
			wait_n(3);
			chk({2'h0, pwm}, 8'h2a);
			chk({7'h0, irq}, 8'h01);
			chk_rd(POS_ADDR_BRAKE_CONTROL_DATA, {1'b1, s, 6'h2a});
			wr_reg(POS_ADDR_BRAKE_CONTROL_DATA, {1'b0, s, 6'h2a});
			chk_rd(POS_ADDR_BRAKE_CONTROL_DATA, {1'b0, s, 6'h2a});
			chk({2'h0, pwm}, 8'h2a);
			wr_reg(POS_ADDR_IRQ_STATUS, 8'h01);
			wait_n(2);
			chk({7'h0, irq}, 8'h00);
			@(posedge clk);
			run <= 1'b1;
			wait_n(4);
			chk({2'h0, pwm}, 8'h00);
			@(posedge clk);
			run    <= 1'b0;
			brk_en <= 1'b0;
		end
		@(posedge clk);
		brk_pin <= 1'b0;
		wait_n(2);
		chk_rd(POS_ADDR_BRAKE_CONTROL_DATA, 8'h6a);
		done("brake");
		wr_reg(POS_ADDR_IRQ_MASK, 8'h00);
		wr_reg(POS_ADDR_WRITE_UNLOCK, POS_UNLOCK_KEY_1);
		wr_reg(POS_ADDR_WRITE_UNLOCK, 8'h00);
		wr_reg(POS_ADDR_WRITE_UNLOCK, POS_UNLOCK_KEY_2);
		chk_rd(POS_ADDR_WRITE_UNLOCK, 8'h00);
		wr_reg(POS_ADDR_WRITE_UNLOCK, POS_UNLOCK_KEY_1);
		wr_reg(POS_ADDR_WRITE_UNLOCK, POS_UNLOCK_KEY_2);
		chk_rd(POS_ADDR_WRITE_UNLOCK, 8'h01);
		wait_n(4);
		chk_rd(POS_ADDR_WRITE_UNLOCK, 8'h00);
		wr_reg(POS_ADDR_DEADTIME_COUNT_LOW, 8'h55);
		chk_rd(POS_ADDR_DEADTIME_COUNT_LOW, 8'h00);
		chk_rd(POS_ADDR_IRQ_STATUS, 8'h02);
		chk({7'h0, irq}, 8'h00);
		wr_reg(POS_ADDR_IRQ_MASK, 8'h02);
		chk_rd(POS_ADDR_IRQ_MASK, 8'h02);
		wait_n(2);
		chk({7'h0, irq}, 8'h01);
		wr_reg(POS_ADDR_IRQ_STATUS, 8'h02);
		wait_n(2);
		chk({7'h0, irq}, 8'h00);
		done("protection");
		@(posedge clk);
		comp <= 1'b1;
		measure(base);
		unlock_wr(POS_ADDR_DEADTIME_ENABLE, 8'h01);
		unlock_wr(POS_ADDR_DEADTIME_COUNT_LOW, 8'h05);
		chk_rd(POS_ADDR_DEADTIME_COUNT_LOW, 8'h05);
		measure(n);
		chkn(n, base + 6);
		@(posedge clk);
		comp <= 1'b0;
		measure(n);
		chkn(n, base);
		@(posedge clk);
		comp <= 1'b1;
		unlock_wr(POS_ADDR_DEADTIME_ENABLE, 8'h11);
		unlock_wr(POS_ADDR_DEADTIME_COUNT_LOW, 8'h02);
		measure(n);
		chkn(n, base + 259);
		unlock_wr(POS_ADDR_DEADTIME_ENABLE, 8'h10);
		measure(n);
		chkn(n, base);
		chk({5'h0, short}, 8'h00);
		done("deadtime");
		@(posedge clk);
		reset_n <= 1'b0;
		wait_n(2);
		@(posedge clk);
		reset_n <= 1'b1;
		chk_rd(POS_ADDR_DEADTIME_COUNT_LOW, 8'h00);
		chk_rd(POS_ADDR_BRAKE_CONTROL_DATA, 8'h00);
		done("mid-run reset");
		end_sim();
	end
endmodule // pos_output_stage_test
